// ### rtl/uect_pkg.sv
// shared constants and types for the endpoint-zero control transfer logic
package uect_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_OUT0_CFG = 8'h00;
  localparam logic [7:0] OFS_IN0_CFG  = 8'h04;
  localparam logic [7:0] OFS_OUT0_CNT = 8'h08;
  localparam logic [7:0] OFS_IN0_CNT  = 8'h0C;
  localparam logic [7:0] OFS_STAT     = 8'h10;
  localparam logic [7:0] OFS_OUT_TYPE = 8'h14;
  localparam logic [7:0] OFS_IN_TYPE  = 8'h18;
  localparam logic [7:0] OFS_SETUP_LO = 8'h20;
  localparam logic [7:0] OFS_SETUP_HI = 8'h24;
  localparam logic [7:0] OFS_OBUF_LO  = 8'h28;
  localparam logic [7:0] OFS_OBUF_HI  = 8'h2C;
  // endpoint configuration byte fields
  localparam int         CFG_W     = 5;
  localparam int         CFG_STALL = 0;
  localparam int         CFG_TOG   = 1;
  localparam int         CFG_NAK   = 2;
  localparam int         CFG_IE    = 3;
  localparam int         CFG_EN    = 4;
  localparam logic [4:0] CFG_RST   = 5'h00;
  // status register fields
  localparam int         SB_PEND   = 0;
  localparam int         SB_SETUP  = 1;
  localparam int         SB_OUT    = 2;
  localparam int         SB_IN     = 3;
  // packet sizes
  localparam int         MAXP      = 8;
  localparam logic [3:0] MAXP_CNT  = 4'h8;
  localparam logic [3:0] CNT_RST   = 4'h0;
  // further endpoints and their transfer types
  localparam int         N_EP      = 7;
  localparam logic [1:0] EP_ISO    = 2'h1;
  localparam logic [13:0] TYPE_RST = 14'h0000;
  localparam logic [3:0] EP_ZERO   = 4'h0;
  // link codes
  localparam logic [1:0] TOK_OUT   = 2'h0;
  localparam logic [1:0] TOK_IN    = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;
  localparam logic [1:0] HS_ACK    = 2'h0;
  localparam logic [1:0] HS_NAK    = 2'h1;
  localparam logic [1:0] HS_STALL  = 2'h2;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_INWAIT} uect_state_t;
endpackage : uect_pkg

// ### rtl/uect_rxbuf.sv
// staging buffer that gathers the bytes of one received data packet
`timescale 1ns/1ps
module uect_rxbuf (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clr,
  input  wire logic        byte_vld,
  input  wire logic [7:0]  byte_in,
  output logic      [63:0] bytes,
  output logic      [3:0]  cnt,
  output logic             ovf
);
  logic [7:0] mem_ff [uect_pkg::MAXP];
  logic [3:0] cnt_ff;
  logic       ovf_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      cnt_ff <= uect_pkg::CNT_RST;
      ovf_ff <= 1'b0;
    end else if (byte_vld) begin
      if (cnt_ff == uect_pkg::MAXP_CNT) begin
        ovf_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < uect_pkg::MAXP; g++) begin : g_byte
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          mem_ff[g] <= 8'h00;
        end else if (byte_vld && cnt_ff == 4'(g)) begin
          mem_ff[g] <= byte_in;
        end
      end
      assign bytes[g*8 +: 8] = mem_ff[g];
    end
  endgenerate

  assign cnt = cnt_ff;
  assign ovf = ovf_ff;
endmodule : uect_rxbuf

// ### rtl/uect_ctrl.sv
// endpoint-zero control transfer engine with its register slave
//
// What this block does
// - seven in, seven out endpoints, typed per endpoint.
// - isochronous endpoints are flagged for the DMA.
// - good setup stored, pending set, ACK, interrupt.
// - pending setup forces NAK on data/status stages.
// - stall bits make data/status stages answer STALL unless a setup is pending.
// - clearing setup interrupt also clears setup pending.
// - good out packet stored, counted, toggled, ACKed.
// - out packet gets NAK or STALL per flags.
// - corrupted data packet gets no handshake.
// - in token sends packet; ACK toggles, flags, interrupts.
// - in token gets NAK or STALL per flags.
// - missing host ACK leaves state for a resend.
// - no-data write is setup then in status.
// - data write is setup, out stages, in status.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
module uect_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sie_tok_vld,
  input  wire logic [1:0]  sie_tok_pid,
  input  wire logic [3:0]  sie_tok_ep,
  input  wire logic        sie_rx_vld,
  input  wire logic [7:0]  sie_rx_data,
  input  wire logic        sie_rx_end,
  input  wire logic        sie_rx_err,
  input  wire logic        sie_rx_data1,
  input  wire logic        sie_host_ack,
  input  wire logic        sie_host_to,
  output logic             hs_vld,
  output logic      [1:0]  hs_code,
  output logic             tx_go,
  output logic      [3:0]  tx_len,
  output logic             tx_data1,
  output logic             irq_setup,
  output logic             irq_out0,
  output logic             irq_in0,
  output logic      [6:0]  dma_out_iso,
  output logic      [6:0]  dma_in_iso
);
  // register slave state
  logic                   awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic                   aw_full_ff, w_full_ff;
  logic [7:0]             waddr_ff;
  logic [31:0]            wdata_ff, rdata_ff;
  logic [3:0]             wstrb_ff;
  logic [1:0]             bresp_ff, rresp_ff;
  logic                   nxt_aw_full, nxt_w_full, nxt_bvalid, nxt_rvalid;
  logic                   wr_do, rd_do, wr_hit;
  logic [31:0]            nxt_rdata;
  logic                   nxt_rhit;
  // endpoint state
  logic [uect_pkg::CFG_W-1:0] out_cfg_ff, in_cfg_ff;
  logic [3:0]             out_cnt_ff, in_cnt_ff;
  logic [63:0]            setup_buf_ff, out_buf_ff;
  logic                   pending_ff, setup_int_ff, out_int_ff, in_int_ff;
  logic [13:0]            out_type_ff, in_type_ff;
  logic [6:0]             out_iso, in_iso, out_iso_ff, in_iso_ff;
  // transaction state
  uect_pkg::uect_state_t  state_ff, nxt_state;
  logic                   tok_setup_ff;
  logic                   hs_vld_ff, nxt_hs_vld, tx_go_ff, tx_data1_ff;
  logic [1:0]             hs_code_ff, nxt_hs_code;
  logic [3:0]             tx_len_ff;
  logic                   irq_setup_ff, irq_out0_ff, irq_in0_ff;
  // staging buffer
  logic [63:0]            rx_bytes;
  logic [3:0]             rx_cnt;
  logic                   rx_ovf;
  // decoded events
  logic                   tok_ep0, tok_rx_start, in_tok, rx_done, rx_good;
  logic                   setup_ok, out_data, out_acc, in_go, in_done;
  logic                   wr_stat, wr_out_cfg, wr_in_cfg;

  // ---------------- AXI4-Lite slave ----------------
  // address and data are taken in either order; the write happens once both are held
  assign wr_do       = aw_full_ff && w_full_ff && !bvalid_ff;
  assign nxt_aw_full = (aw_full_ff && !wr_do) || (s_axi_awvalid && awready_ff);
  assign nxt_w_full  = (w_full_ff && !wr_do) || (s_axi_wvalid && wready_ff);
  assign nxt_bvalid  = wr_do || (bvalid_ff && !s_axi_bready);
  assign rd_do       = s_axi_arvalid && arready_ff;
  assign nxt_rvalid  = rd_do || (rvalid_ff && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= uect_pkg::RESP_OKAY;
      waddr_ff   <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff  <= nxt_w_full;
      awready_ff <= !nxt_aw_full && !nxt_bvalid;
      wready_ff  <= !nxt_w_full && !nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      if (s_axi_awvalid && awready_ff) begin
        waddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_do) begin
        bresp_ff <= wr_hit ? uect_pkg::RESP_OKAY : uect_pkg::RESP_SLVERR;
      end
    end
  end

  always_comb begin
    case (waddr_ff)
      uect_pkg::OFS_OUT0_CFG, uect_pkg::OFS_IN0_CFG, uect_pkg::OFS_OUT0_CNT,
      uect_pkg::OFS_IN0_CNT, uect_pkg::OFS_STAT, uect_pkg::OFS_OUT_TYPE,
      uect_pkg::OFS_IN_TYPE: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  assign wr_stat    = wr_do && waddr_ff == uect_pkg::OFS_STAT && wstrb_ff[0];
  assign wr_out_cfg = wr_do && waddr_ff == uect_pkg::OFS_OUT0_CFG && wstrb_ff[0];
  assign wr_in_cfg  = wr_do && waddr_ff == uect_pkg::OFS_IN0_CFG && wstrb_ff[0];

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rhit  = 1'b1;
    case (s_axi_araddr)
      uect_pkg::OFS_OUT0_CFG: nxt_rdata[uect_pkg::CFG_W-1:0] = out_cfg_ff;
      uect_pkg::OFS_IN0_CFG:  nxt_rdata[uect_pkg::CFG_W-1:0] = in_cfg_ff;
      uect_pkg::OFS_OUT0_CNT: nxt_rdata[3:0] = out_cnt_ff;
      uect_pkg::OFS_IN0_CNT:  nxt_rdata[3:0] = in_cnt_ff;
      uect_pkg::OFS_STAT:     nxt_rdata[3:0] = {in_int_ff, out_int_ff, setup_int_ff, pending_ff};
      uect_pkg::OFS_OUT_TYPE: nxt_rdata[13:0] = out_type_ff;
      uect_pkg::OFS_IN_TYPE:  nxt_rdata[13:0] = in_type_ff;
      uect_pkg::OFS_SETUP_LO: nxt_rdata = setup_buf_ff[31:0];
      uect_pkg::OFS_SETUP_HI: nxt_rdata = setup_buf_ff[63:32];
      uect_pkg::OFS_OBUF_LO:  nxt_rdata = out_buf_ff[31:0];
      uect_pkg::OFS_OBUF_HI:  nxt_rdata = out_buf_ff[63:32];
      default:                nxt_rhit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= uect_pkg::RESP_OKAY;
    end else begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (rd_do) begin
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rhit ? uect_pkg::RESP_OKAY : uect_pkg::RESP_SLVERR;
      end
    end
  end

  // ---------------- further endpoints ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_type_ff <= uect_pkg::TYPE_RST;
      in_type_ff  <= uect_pkg::TYPE_RST;
    end else if (wr_do) begin
      if (waddr_ff == uect_pkg::OFS_OUT_TYPE && wstrb_ff[0]) out_type_ff[7:0]  <= wdata_ff[7:0];
      if (waddr_ff == uect_pkg::OFS_OUT_TYPE && wstrb_ff[1]) out_type_ff[13:8] <= wdata_ff[13:8];
      if (waddr_ff == uect_pkg::OFS_IN_TYPE && wstrb_ff[0])  in_type_ff[7:0]   <= wdata_ff[7:0];
      if (waddr_ff == uect_pkg::OFS_IN_TYPE && wstrb_ff[1])  in_type_ff[13:8]  <= wdata_ff[13:8];
    end
  end

  genvar e;
  generate
    for (e = 0; e < uect_pkg::N_EP; e++) begin : g_ep
      // streaming endpoints bypass firmware and go to the DMA channels
      assign out_iso[e] = out_type_ff[2*e +: 2] == uect_pkg::EP_ISO;
      assign in_iso[e]  = in_type_ff[2*e +: 2] == uect_pkg::EP_ISO;
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_iso_ff <= 7'h00;
      in_iso_ff  <= 7'h00;
    end else begin
      out_iso_ff <= out_iso;
      in_iso_ff  <= in_iso;
    end
  end

  // ---------------- transaction decode ----------------
  assign tok_ep0      = sie_tok_vld && sie_tok_ep == uect_pkg::EP_ZERO && state_ff != uect_pkg::ST_RX;
  assign tok_rx_start = tok_ep0 && (sie_tok_pid == uect_pkg::TOK_SETUP || sie_tok_pid == uect_pkg::TOK_OUT);
  assign in_tok       = tok_ep0 && sie_tok_pid == uect_pkg::TOK_IN;
  assign rx_done      = state_ff == uect_pkg::ST_RX && sie_rx_end;
  assign rx_good      = rx_done && !sie_rx_err && !rx_ovf;
  assign setup_ok     = rx_good && tok_setup_ff && rx_cnt == uect_pkg::MAXP_CNT;
  assign out_data     = rx_good && !tok_setup_ff;
  assign out_acc      = out_data && !pending_ff && out_cfg_ff[uect_pkg::CFG_EN] &&
                        !out_cfg_ff[uect_pkg::CFG_STALL] && !out_cfg_ff[uect_pkg::CFG_NAK] &&
                        sie_rx_data1 == out_cfg_ff[uect_pkg::CFG_TOG];
  assign in_go        = in_tok && !pending_ff && in_cfg_ff[uect_pkg::CFG_EN] &&
                        !in_cfg_ff[uect_pkg::CFG_STALL] && !in_cfg_ff[uect_pkg::CFG_NAK];
  assign in_done      = state_ff == uect_pkg::ST_INWAIT && sie_host_ack;

  uect_rxbuf u_rxbuf (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clr      (tok_rx_start),
    .byte_vld (sie_rx_vld && state_ff == uect_pkg::ST_RX),
    .byte_in  (sie_rx_data),
    .bytes    (rx_bytes),
    .cnt      (rx_cnt),
    .ovf      (rx_ovf)
  );

  // handshake choice; a pending setup outranks stall, stall outranks no-ack
  always_comb begin
    nxt_hs_vld  = 1'b0;
    nxt_hs_code = uect_pkg::HS_ACK;
    if (setup_ok) begin
      nxt_hs_vld = 1'b1;
    end else if (out_data && pending_ff) begin
      nxt_hs_vld  = 1'b1;
      nxt_hs_code = uect_pkg::HS_NAK;
    end else if (out_data && out_cfg_ff[uect_pkg::CFG_EN]) begin
      nxt_hs_vld = 1'b1;
      if (out_cfg_ff[uect_pkg::CFG_STALL]) begin
        nxt_hs_code = uect_pkg::HS_STALL;
      end else if (out_cfg_ff[uect_pkg::CFG_NAK]) begin
        nxt_hs_code = uect_pkg::HS_NAK;
      end
    end else if (in_tok && pending_ff) begin
      nxt_hs_vld  = 1'b1;
      nxt_hs_code = uect_pkg::HS_NAK;
    end else if (in_tok && in_cfg_ff[uect_pkg::CFG_EN] && !in_go) begin
      nxt_hs_vld  = 1'b1;
      nxt_hs_code = in_cfg_ff[uect_pkg::CFG_STALL] ? uect_pkg::HS_STALL
                                                   : uect_pkg::HS_NAK;
    end
  end

  // a setup, then any out stages, then the in status stage
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      uect_pkg::ST_IDLE, uect_pkg::ST_INWAIT: begin
        if (tok_rx_start) begin
          nxt_state = uect_pkg::ST_RX;
        end else if (in_go) begin
          nxt_state = uect_pkg::ST_INWAIT;
        end else if (state_ff == uect_pkg::ST_INWAIT && (sie_host_ack || sie_host_to)) begin
          nxt_state = uect_pkg::ST_IDLE;
        end
      end
      uect_pkg::ST_RX: begin
        if (sie_rx_end) nxt_state = uect_pkg::ST_IDLE;
      end
      default: nxt_state = uect_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff     <= uect_pkg::ST_IDLE;
      tok_setup_ff <= 1'b0;
      hs_vld_ff    <= 1'b0;
      hs_code_ff   <= uect_pkg::HS_ACK;
      tx_go_ff     <= 1'b0;
      tx_len_ff    <= uect_pkg::CNT_RST;
      tx_data1_ff  <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      hs_vld_ff  <= nxt_hs_vld;
      hs_code_ff <= nxt_hs_code;
      tx_go_ff   <= in_go;
      if (tok_rx_start) tok_setup_ff <= sie_tok_pid == uect_pkg::TOK_SETUP;
      if (in_go) begin
        tx_len_ff   <= in_cnt_ff;
        tx_data1_ff <= in_cfg_ff[uect_pkg::CFG_TOG];
      end
    end
  end

  // ---------------- endpoint-zero registers ----------------
  // hardware updates come last so they win over a firmware write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_cfg_ff <= uect_pkg::CFG_RST;
      out_cnt_ff <= uect_pkg::CNT_RST;
      out_buf_ff <= 64'h0000_0000_0000_0000;
    end else begin
      if (wr_out_cfg) out_cfg_ff <= wdata_ff[uect_pkg::CFG_W-1:0];
      if (wr_do && waddr_ff == uect_pkg::OFS_OUT0_CNT && wstrb_ff[0]) out_cnt_ff <= wdata_ff[3:0];
      if (out_acc) begin
        out_buf_ff                     <= rx_bytes;
        out_cnt_ff                     <= rx_cnt;
        out_cfg_ff[uect_pkg::CFG_TOG]  <= !out_cfg_ff[uect_pkg::CFG_TOG];
        out_cfg_ff[uect_pkg::CFG_NAK]  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_cfg_ff <= uect_pkg::CFG_RST;
      in_cnt_ff <= uect_pkg::CNT_RST;
    end else begin
      if (wr_in_cfg) in_cfg_ff <= wdata_ff[uect_pkg::CFG_W-1:0];
      if (wr_do && waddr_ff == uect_pkg::OFS_IN0_CNT && wstrb_ff[0]) in_cnt_ff <= wdata_ff[3:0];
      if (in_done) begin
        in_cfg_ff[uect_pkg::CFG_TOG] <= !in_cfg_ff[uect_pkg::CFG_TOG];
        in_cfg_ff[uect_pkg::CFG_NAK] <= 1'b1;
      end
    end
  end

  // write-one-to-clear flags; a new event in the clearing cycle still sets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_ff   <= 1'b0;
      setup_int_ff <= 1'b0;
      out_int_ff   <= 1'b0;
      in_int_ff    <= 1'b0;
      setup_buf_ff <= 64'h0000_0000_0000_0000;
    end else begin
      if (wr_stat && wdata_ff[uect_pkg::SB_SETUP]) begin
        setup_int_ff <= 1'b0;
        pending_ff   <= 1'b0;
      end
      if (wr_stat && wdata_ff[uect_pkg::SB_OUT]) out_int_ff <= 1'b0;
      if (wr_stat && wdata_ff[uect_pkg::SB_IN])  in_int_ff  <= 1'b0;
      if (setup_ok) begin
        setup_buf_ff <= rx_bytes;
        pending_ff   <= 1'b1;
        setup_int_ff <= 1'b1;
      end
      if (out_acc) out_int_ff <= 1'b1;
      if (in_done) in_int_ff  <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_setup_ff <= 1'b0;
      irq_out0_ff  <= 1'b0;
      irq_in0_ff   <= 1'b0;
    end else begin
      irq_setup_ff <= setup_int_ff;
      irq_out0_ff  <= out_int_ff && out_cfg_ff[uect_pkg::CFG_IE];
      irq_in0_ff   <= in_int_ff && in_cfg_ff[uect_pkg::CFG_IE];
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign hs_vld        = hs_vld_ff;
  assign hs_code       = hs_code_ff;
  assign tx_go         = tx_go_ff;
  assign tx_len        = tx_len_ff;
  assign tx_data1      = tx_data1_ff;
  assign irq_setup     = irq_setup_ff;
  assign irq_out0      = irq_out0_ff;
  assign irq_in0       = irq_in0_ff;
  assign dma_out_iso   = out_iso_ff;
  assign dma_in_iso    = in_iso_ff;

  // ---------------- assertions ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_hs(logic [1:0] code);
    hs_vld_ff && hs_code_ff == code;
  endsequence
  sequence s_in_pulse;
    tx_go_ff ##1 !tx_go_ff;
  endsequence
  sequence s_hs_none_tx;
    s_in_pulse and !hs_vld_ff;
  endsequence

  setup_ack_a: assert property (setup_ok |=> s_hs(uect_pkg::HS_ACK) and
      (pending_ff && setup_int_ff ##1 irq_setup_ff))
    else $error("setup not acknowledged and flagged");
  pend_nak_a: assert property (out_data && pending_ff |=> s_hs(uect_pkg::HS_NAK))
    else $error("pending setup did not force NAK");
  in_stall_a: assert property (in_tok && !pending_ff && in_cfg_ff[uect_pkg::CFG_EN] &&
      in_cfg_ff[uect_pkg::CFG_STALL] |=> s_hs(uect_pkg::HS_STALL) && !tx_go_ff)
    else $error("stalled in endpoint did not STALL");
  clr_pend_a: assert property (wr_stat && wdata_ff[uect_pkg::SB_SETUP] && !setup_ok
      |=> !pending_ff && !setup_int_ff)
    else $error("setup interrupt clear left pending set");
  out_take_a: assert property (out_acc |=> s_hs(uect_pkg::HS_ACK) and
      (out_cfg_ff[uect_pkg::CFG_TOG] != $past(out_cfg_ff[uect_pkg::CFG_TOG]) &&
       out_cfg_ff[uect_pkg::CFG_NAK] && out_int_ff && out_cnt_ff == $past(rx_cnt)))
    else $error("accepted out packet not recorded");
  out_nak_a: assert property (out_data && !pending_ff && out_cfg_ff[uect_pkg::CFG_EN] &&
      !out_cfg_ff[uect_pkg::CFG_STALL] && out_cfg_ff[uect_pkg::CFG_NAK]
      |=> s_hs(uect_pkg::HS_NAK) && $stable(out_cnt_ff))
    else $error("busy out endpoint did not NAK");
  crc_nohs_a: assert property (rx_done && sie_rx_err |=> !hs_vld_ff)
    else $error("handshake sent for corrupted packet");
  in_send_a: assert property (in_go |=> s_hs_none_tx)
    else $error("in token did not start one packet");
  in_done_a: assert property (in_done |=> in_cfg_ff[uect_pkg::CFG_NAK] && in_int_ff &&
      in_cfg_ff[uect_pkg::CFG_TOG] != $past(in_cfg_ff[uect_pkg::CFG_TOG]))
    else $error("in completion not recorded");
  in_nak_a: assert property (in_tok && !pending_ff && in_cfg_ff[uect_pkg::CFG_EN] &&
      !in_cfg_ff[uect_pkg::CFG_STALL] && in_cfg_ff[uect_pkg::CFG_NAK] |=> s_hs(uect_pkg::HS_NAK))
    else $error("busy in endpoint did not NAK");
  in_retry_a: assert property (state_ff == uect_pkg::ST_INWAIT && sie_host_to && !sie_host_ack &&
      !wr_in_cfg && !in_done |=> $stable(in_cfg_ff) && !$rose(in_int_ff))
    else $error("missing host handshake changed state");
endmodule : uect_ctrl

// ### tb/uect_host.sv
// host-side model driving tokens, data packets and handshakes into the link port
`timescale 1ns/1ps
module uect_host (
  input  wire logic       aclk,
  output logic            sie_tok_vld,
  output logic [1:0]      sie_tok_pid,
  output logic [3:0]      sie_tok_ep,
  output logic            sie_rx_vld,
  output logic [7:0]      sie_rx_data,
  output logic            sie_rx_end,
  output logic            sie_rx_err,
  output logic            sie_rx_data1,
  output logic            sie_host_ack,
  output logic            sie_host_to,
  input  wire logic       hs_vld,
  input  wire logic [1:0] hs_code,
  input  wire logic       tx_go
);
  initial begin
    {sie_tok_vld, sie_tok_pid, sie_tok_ep, sie_rx_vld, sie_rx_end} = '0;
    {sie_rx_data, sie_rx_err, sie_rx_data1, sie_host_ack, sie_host_to} = '0;
  end
  // token, then bytes, then end of packet for setup and out only; r is 3 when nothing answers, 4 for a data packet
  task automatic xfer(input logic [1:0] pid, input int n, input logic [63:0] b,
                      input logic d1, input logic er, output logic [2:0] r);
    @(posedge aclk);
    sie_tok_vld <= 1'b1;
    sie_tok_pid <= pid;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      sie_tok_vld <= 1'b0;
      sie_rx_vld  <= 1'b1;
      sie_rx_data <= b[8*i+:8];
    end
    if (pid != uect_pkg::TOK_IN) begin
      @(posedge aclk);
      {sie_tok_vld, sie_rx_vld} <= 2'h0;
      sie_rx_data  <= ~sie_rx_data; // released data line keeps moving
      {sie_rx_end, sie_rx_err, sie_rx_data1} <= {1'b1, er, d1};
    end
    @(posedge aclk);
    {sie_tok_vld, sie_rx_vld, sie_rx_end, sie_rx_err} <= 4'h0;
    r = 3'h3;
    repeat (3) begin
      @(negedge aclk);
      if (hs_vld) r = {1'b0, hs_code};
      if (tx_go) r = 3'h4;
    end
    @(posedge aclk);
  endtask : xfer
  // host answer to our in packet: ack, or silence
  task automatic ans(input logic ack);
    @(posedge aclk);
    {sie_host_ack, sie_host_to} <= {ack, !ack};
    @(posedge aclk);
    {sie_host_ack, sie_host_to} <= 2'h0;
  endtask : ans
endmodule : uect_host

// ### tb/tb.sv
// testbench: endpoint-zero control write sequences against the host model
`timescale 1ns/1ps
module tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, irq_setup, irq_out0, irq_in0, hs_vld, tx_go, tx_data1;
  logic sie_tok_vld, sie_rx_vld, sie_rx_end, sie_rx_err, sie_rx_data1, sie_host_ack, sie_host_to;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sie_rx_data;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, s = 32'hE56467FB;
  logic [3:0]  s_axi_wstrb = 4'hF, sie_tok_ep, tx_len;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sie_tok_pid, hs_code;
  logic [6:0]  dma_out_iso, dma_in_iso;
  logic [63:0] pk;
  logic [2:0]  r;
  int          n_mismatch = 0, checked = 0, cyc = 0, ocfg, icfg, n;
  always #5 aclk = ~aclk;
  uect_ctrl DUT (.*);
  uect_host host (.*);
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // ready sampled at the rising edge; bready and rready stay high so no edge is missed
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", e, s_axi_bresp);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] e,
                     input logic [1:0] er = 2'h0);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(nm, e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask : rdc
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(uect_pkg::OFS_OUT_TYPE, 32'h1);
    wr(uect_pkg::OFS_IN_TYPE, 32'h1000);
    @(posedge aclk);
    chk("dma_iso", 32'h1, dma_out_iso);
    chk("dma_in_iso", 32'h40, dma_in_iso);
    ocfg = 'h1A; // enabled, interrupt on, toggle set for a write
    icfg = 'h18;
    wr(uect_pkg::OFS_OUT0_CFG, ocfg);
    wr(uect_pkg::OFS_IN0_CFG, icfg);
    pk = {xs(), xs()};
    host.xfer(uect_pkg::TOK_SETUP, 8, pk, 0, 0, r);
    chk("setup_hs", uect_pkg::HS_ACK, r);
    chk("irq_setup", 1, irq_setup);
    rdc(uect_pkg::OFS_STAT, "stat", 3);
    rdc(uect_pkg::OFS_SETUP_HI, "setup_hi", pk[63:32]);
    host.xfer(uect_pkg::TOK_OUT, 8, pk, 1, 0, r);
    chk("pend_hs", uect_pkg::HS_NAK, r);
    wr(uect_pkg::OFS_STAT, 2);
    rdc(uect_pkg::OFS_STAT, "stat", 0);
    for (int i = 0; i < 2; i++) begin
      pk = {xs(), xs()};
      n = i ? 8 : 1 + xs() % 7;
      host.xfer(uect_pkg::TOK_OUT, n, pk, ocfg[1], 0, r);
      chk("out_hs", uect_pkg::HS_ACK, r);
      chk("irq_out0", 1, irq_out0);
      ocfg = (ocfg ^ 2) | 4;
      rdc(uect_pkg::OFS_OUT0_CNT, "cnt", n);
      rdc(uect_pkg::OFS_OUT0_CFG, "ocfg", ocfg);
      if (i) rdc(uect_pkg::OFS_OBUF_HI, "obuf_hi", pk[63:32]);
      host.xfer(uect_pkg::TOK_OUT, n, pk, ocfg[1], 0, r);
      chk("nak_hs", uect_pkg::HS_NAK, r);
      wr(uect_pkg::OFS_STAT, 4);
      ocfg = ocfg & 'h1B;
      wr(uect_pkg::OFS_OUT0_CFG, ocfg);
    end
    host.xfer(uect_pkg::TOK_OUT, 8, pk, ocfg[1], 1, r);
    chk("err_hs", 3, r);
    wr(uect_pkg::OFS_IN0_CNT, 0);
    icfg = 'h1A;
    wr(uect_pkg::OFS_IN0_CFG, icfg);
    for (int i = 0; i < 2; i++) begin
      host.xfer(uect_pkg::TOK_IN, 0, pk, 0, 0, r);
      chk("in_tx", 4, r);
      chk("tx_len", 0, tx_len);
      chk("tx_data1", 1, tx_data1);
      host.ans(i[0]);
      if (i) icfg = (icfg ^ 2) | 4;
      rdc(uect_pkg::OFS_IN0_CFG, "icfg", icfg);
    end
    chk("irq_in0", 1, irq_in0);
    host.xfer(uect_pkg::TOK_IN, 0, pk, 0, 0, r);
    chk("in_nak", uect_pkg::HS_NAK, r);
    wr(uect_pkg::OFS_OUT0_CFG, ocfg | 1);
    wr(uect_pkg::OFS_IN0_CFG, icfg | 1);
    host.xfer(uect_pkg::TOK_IN, 0, pk, 0, 0, r);
    chk("in_stall", uect_pkg::HS_STALL, r);
    host.xfer(uect_pkg::TOK_OUT, 4, pk, ocfg[1], 0, r);
    chk("out_stall", uect_pkg::HS_STALL, r);
    host.xfer(uect_pkg::TOK_SETUP, 8, pk, 0, 0, r);
    chk("setup_hs", uect_pkg::HS_ACK, r);
    host.xfer(uect_pkg::TOK_IN, 0, pk, 0, 0, r);
    chk("pend_stall", uect_pkg::HS_NAK, r);
    wr(8'hFC, 32'h0, uect_pkg::RESP_SLVERR);
    rdc(8'hFC, "unmapped", 0, uect_pkg::RESP_SLVERR);
    tally_and_finish();
  end
endmodule : tb
